//--- include/tksc_cfg.svh
// Constants for the touch key option strap and sync control block
// Summary of operation
// - Read option straps at power-up and every 10 s while no key detects
// - One reading is 25 samples over 250 us; all must agree
// - Speed strap low selects fast with spread drive, high selects slow with sync
// - Slow mode responds in about 100 ms, fast mode in about 60 ms
// - Sync honoured only in slow mode; spread drive only in fast mode
// - Timeout straps: LH 10 s, HL 60 s, HH toggle 10 s, LL none
// - Timeouts are counted in nominal 100 kHz oscillator periods, except with sync in slow mode
// - A stuck-key timeout recalibrates only that key
// - Toggle mode inverts a key output at each new confirmed detection
// - A timeout in toggle mode leaves the toggle level alone
// - All four keys burst together in lockstep
// - In slow mode a sync pulse wakes one burst, then sleep again
// - Without sync for about 90 ms the device wakes by itself
// - Fast sync shortens the interval; slow sync never lengthens it
// - With sync in slow mode timeouts count bursts assuming 55 Hz
// - Output needs six consecutive detections; one miss clears the integrator
`ifndef TKSC_CFG_SVH
`define TKSC_CFG_SVH
`define TKSC_CLK_HZ 200000000
`define TKSC_OSC_HZ 100000
`define TKSC_TICK_CYC (`TKSC_CLK_HZ / `TKSC_OSC_HZ)
`define TKSC_MS_TK(ms) ((ms) * (`TKSC_OSC_HZ / 1000))
`define TKSC_KEYS 4
`define TKSC_OPT_PERIOD_S 10
`define TKSC_OPT_SAMPLES 25
`define TKSC_OPT_WINDOW_US 250
`define TKSC_OPT_SPACE_TK (`TKSC_OPT_WINDOW_US * (`TKSC_OSC_HZ / 1000) / (`TKSC_OPT_SAMPLES * 1000))
`define TKSC_SLOW_GAP_MS 90
`define TKSC_FAST_GAP_MS 6
`define TKSC_BURST_MS 4
`define TKSC_TMO_SHORT_S 10
`define TKSC_TMO_LONG_S 60
`define TKSC_SYNC_HZ 55
`define TKSC_INTEG_LIMIT 6
`define TKSC_ADDR_CTRL 12'h000
`define TKSC_ADDR_STAT 12'h004
`define TKSC_ADDR_OPT 12'h008
`define TKSC_ADDR_GAP 12'h00c
`define TKSC_CTRL_RUN 0
`define TKSC_CTRL_REREAD 1
`define TKSC_ST_OUT 0
`define TKSC_ST_ACT 4
`define TKSC_ST_PEND 8
`define TKSC_ST_SLOW 12
`define TKSC_ST_TGL 13
`define TKSC_ST_SYNC 14
`define TKSC_ST_INF 15
`define TKSC_ST_LONG 16
`define TKSC_ST_STATE 20
`define TKSC_OPT_STRAPS 0
`define TKSC_OPT_BUSY 4
`define TKSC_OPT_VALID 5
`define TKSC_OPT_REJ 8
`define TKSC_STRAP_SPEED 0
`define TKSC_STRAP_A 1
`define TKSC_STRAP_B 2
`endif

//--- include/tksc_pkg.sv
// Types shared by the touch key option and sync control modules
package tksc_pkg;
    typedef enum logic [1:0] {
        tksc_sleep = 2'h0,
        tksc_burst = 2'h1,
        tksc_eval = 2'h3,
        tksc_hold = 2'h2
    } tksc_state_t;

    typedef struct packed {
        logic busy;
        logic valid;
        logic agree;
        logic reject;
        logic [4:0] cnt;
        logic [3:0] space;
        logic [2:0] first;
        logic [2:0] held;
    } tksc_rd_t;

    typedef struct packed {
        logic [2:0] integ;
        logic active;
        logic tgl;
        logic recal;
        logic [22:0] tmr;
    } tksc_key_t;

    typedef struct packed {
        tksc_state_t st;
        logic [10:0] tick_cnt;
        logic tick;
        logic [13:0] gap;
        logic [13:0] last_gap;
        logic [8:0] bcnt;
        logic [22:0] opt_tmr;
        logic opt_start;
        logic run;
        logic reread;
        logic sync_prev;
        logic sync_mode;
        logic eval;
        logic unit;
        logic burst;
        logic ss_out;
        logic ss_oe;
        logic [3:0] key_out;
        logic [7:0] rejects;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tksc_main_t;
endpackage: tksc_pkg

//--- include/tksc_opt_if.sv
// Option strap reading handshake between sequencer and reader
`timescale 1ns/1ps
`default_nettype none
interface tksc_opt_if;
    logic start;
    logic busy;
    logic valid;
    logic reject;
    logic [2:0] straps;
    modport rd (input start, output busy, output valid, output reject, output straps);
    modport ctl (output start, input busy, input valid, input reject, input straps);
endinterface: tksc_opt_if
`default_nettype wire

//--- hdl/tksc_opt_reader.sv
// Option strap reader with all-samples-agree filter
`timescale 1ns/1ps
`default_nettype none
`include "tksc_cfg.svh"
module tksc_opt_reader (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic speed_sync_strap,
    input wire logic timeout_strap_a,
    input wire logic timeout_strap_b,
    tksc_opt_if.rd opt
);
    localparam logic [3:0] SPACE_LAST = 4'(`TKSC_OPT_SPACE_TK - 1);
    localparam logic [4:0] SAMPLE_LAST = 5'(`TKSC_OPT_SAMPLES - 1);
    tksc_pkg::tksc_rd_t s;
    tksc_pkg::tksc_rd_t n;
    logic [2:0] pins;

    assign pins = {timeout_strap_b, timeout_strap_a, speed_sync_strap};
    assign opt.busy = s.busy;
    assign opt.valid = s.valid;
    assign opt.reject = s.reject;
    assign opt.straps = s.held;

    always_comb begin
        n = s;
        n.reject = 1'b0;
        if (opt.start && !s.busy) begin
            n.busy = 1'b1;
            n.cnt = '0;
            n.space = '0;
            n.agree = 1'b1;
        end else if (s.busy && tick) begin
            if (s.space != SPACE_LAST) begin
                n.space = s.space + 4'h1;
            end else begin
                n.space = '0;
                if (s.cnt == '0) begin
                    n.first = pins;
                end else if (pins != s.first) begin
                    n.agree = 1'b0;
                end
                if (s.cnt == SAMPLE_LAST) begin
                    n.busy = 1'b0;
                    if (n.agree) begin
                        n.held = n.first;
                        n.valid = 1'b1;
                    end else begin
                        n.reject = 1'b1;
                    end
                end else begin
                    n.cnt = s.cnt + 5'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end
endmodule: tksc_opt_reader
`default_nettype wire

//--- hdl/tksc_key.sv
// Per-key detection integrator, stuck-key timer and toggle latch
`timescale 1ns/1ps
`default_nettype none
`include "tksc_cfg.svh"
module tksc_key (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic eval,
    input wire logic unit,
    input wire logic detect,
    input wire logic tgl_mode,
    input wire logic tmo_inf,
    input wire logic [22:0] limit,
    output logic active,
    output logic tgl_lvl,
    output logic pending,
    output logic recal
);
    localparam logic [2:0] INTEG_LAST = 3'(`TKSC_INTEG_LIMIT - 1);
    tksc_pkg::tksc_key_t s;
    tksc_pkg::tksc_key_t n;

    assign active = s.active;
    assign tgl_lvl = s.tgl;
    assign pending = (s.integ != '0);
    assign recal = s.recal;

    always_comb begin
        n = s;
        n.recal = 1'b0;
        if (eval) begin
            if (!detect) begin
                n.integ = '0;
                n.active = 1'b0;
                n.tmr = '0;
            end else if (!s.active) begin
                if (s.integ == INTEG_LAST) begin
                    n.integ = '0;
                    n.active = 1'b1;
                    n.tgl = tgl_mode ? !s.tgl : s.tgl;
                end else begin
                    n.integ = s.integ + 3'h1;
                end
            end
        end
        // Only this key is recalibrated; toggle level is kept
        if (n.active && unit && !tmo_inf) begin
            if (s.tmr >= limit) begin
                n.recal = 1'b1;
                n.active = 1'b0;
                n.integ = '0;
                n.tmr = '0;
            end else begin
                n.tmr = s.tmr + 23'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end
endmodule: tksc_key
`default_nettype wire

//--- hdl/tksc_top.sv
// Touch key option straps, burst sequencing, sync handling and APB registers
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "tksc_cfg.svh"
module tksc_top #(
    parameter logic [22:0] OPT_PERIOD_TK = 23'(`TKSC_OPT_PERIOD_S * `TKSC_OSC_HZ),
    parameter logic [22:0] TMO_SHORT_TK = 23'(`TKSC_TMO_SHORT_S * `TKSC_OSC_HZ),
    parameter logic [22:0] TMO_LONG_TK = 23'(`TKSC_TMO_LONG_S * `TKSC_OSC_HZ),
    parameter logic [13:0] SLOW_GAP_TK = 14'(`TKSC_MS_TK(`TKSC_SLOW_GAP_MS))
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic speed_sync_strap,
    input wire logic timeout_strap_a,
    input wire logic timeout_strap_b,
    input wire logic sync_ss_in,
    output logic sync_ss_out,
    output logic sync_ss_oe,
    input wire logic [`TKSC_KEYS-1:0] key_detect,
    output logic [`TKSC_KEYS-1:0] direct_level_output,
    output logic [`TKSC_KEYS-1:0] key_recal,
    output logic burst_run
);
    // ------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------
    localparam logic [10:0] TICK_LAST = 11'(`TKSC_TICK_CYC - 1);
    localparam logic [8:0] BURST_LAST = 9'(`TKSC_MS_TK(`TKSC_BURST_MS) - 1);
    localparam logic [13:0] FAST_GAP_TK = 14'(`TKSC_MS_TK(`TKSC_FAST_GAP_MS));
    localparam logic [22:0] SYNC_SHORT = 23'(`TKSC_TMO_SHORT_S * `TKSC_SYNC_HZ);
    localparam logic [22:0] SYNC_LONG = 23'(`TKSC_TMO_LONG_S * `TKSC_SYNC_HZ);

    tksc_pkg::tksc_main_t s;
    tksc_pkg::tksc_main_t n;

    logic slow;
    logic tgl_mode;
    logic tmo_inf;
    logic tmo_long;
    logic sync_units;
    logic sync_rise;
    logic any_act;
    logic any_pend;
    logic [22:0] limit;
    logic [`TKSC_KEYS-1:0] k_act;
    logic [`TKSC_KEYS-1:0] k_tgl;
    logic [`TKSC_KEYS-1:0] k_pend;

    // ------------------------------------------------------------
    // Option reader
    // ------------------------------------------------------------
    tksc_opt_if opt_if();

    assign opt_if.start = s.opt_start;

    tksc_opt_reader u_reader (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(s.tick),
        .speed_sync_strap(speed_sync_strap),
        .timeout_strap_a(timeout_strap_a),
        .timeout_strap_b(timeout_strap_b),
        .opt(opt_if)
    );

    // ------------------------------------------------------------
    // Option decode
    // ------------------------------------------------------------
    assign slow = opt_if.straps[`TKSC_STRAP_SPEED];
    assign tgl_mode = opt_if.straps[`TKSC_STRAP_A] & opt_if.straps[`TKSC_STRAP_B];
    assign tmo_inf = ~opt_if.straps[`TKSC_STRAP_A] & ~opt_if.straps[`TKSC_STRAP_B];
    assign tmo_long = opt_if.straps[`TKSC_STRAP_A] & ~opt_if.straps[`TKSC_STRAP_B];
    assign sync_units = slow & s.sync_mode;
    // Ticks are nominal oscillator periods; sync bursts assume 55 Hz
    assign limit = sync_units ? (tmo_long ? SYNC_LONG : SYNC_SHORT)
                              : (tmo_long ? TMO_LONG_TK : TMO_SHORT_TK);
    assign any_act = |k_act;
    assign any_pend = |k_pend;
    // Edge only counts while asleep, so level during a burst is ignored
    assign sync_rise = slow & sync_ss_in & ~s.sync_prev & (s.st == tksc_pkg::tksc_sleep);

    // ------------------------------------------------------------
    // Key channels
    // ------------------------------------------------------------
    // One shared eval strobe keeps every channel on the same burst
    for (genvar i = 0; i < `TKSC_KEYS; i++) begin : g_key
        tksc_key u_key (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .eval(s.eval),
            .unit(s.unit),
            .detect(key_detect[i]),
            .tgl_mode(tgl_mode),
            .tmo_inf(tmo_inf),
            .limit(limit),
            .active(k_act[i]),
            .tgl_lvl(k_tgl[i]),
            .pending(k_pend[i]),
            .recal(key_recal[i])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic wake;
        logic acc;
        logic [31:0] rd_word;
        wake = 1'b0;
        acc = psel && penable;
        rd_word = '0;
        n = s;
        n.tick = 1'b0;
        n.eval = 1'b0;
        n.opt_start = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.sync_prev = sync_ss_in;

        // Nominal oscillator timebase
        if (s.tick_cnt == TICK_LAST) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = s.tick_cnt + 11'h1;
        end

        // Option reading schedule
        if (s.tick && s.opt_tmr != OPT_PERIOD_TK) begin
            n.opt_tmr = s.opt_tmr + 23'h1;
        end
        // Straps share the sense pins, so a read starts only from sleep, even if a burst wakes in that same cycle
        if (!opt_if.busy && !s.opt_start && s.st == tksc_pkg::tksc_sleep) begin
            if (!opt_if.valid || s.reread || (s.opt_tmr == OPT_PERIOD_TK && !any_act)) begin
                n.opt_start = 1'b1;
                n.opt_tmr = '0;
                n.reread = 1'b0;
            end
        end
        if (opt_if.reject && s.rejects != '1) begin
            n.rejects = s.rejects + 8'h1;
        end

        // Burst sequencer
        unique case (s.st)
            tksc_pkg::tksc_sleep: begin
                if (s.tick && s.gap != '1) begin
                    n.gap = s.gap + 14'h1;
                end
                if (s.run && opt_if.valid && !opt_if.busy && !s.opt_start) begin
                    if (sync_rise) begin
                        n.sync_mode = 1'b1;
                        wake = 1'b1;
                    end else if (slow && any_pend) begin
                        // Confirmation bursts run without sleep
                        wake = 1'b1;
                    end else if (slow && s.gap >= SLOW_GAP_TK) begin
                        n.sync_mode = 1'b0;
                        wake = 1'b1;
                    end else if (!slow && s.gap >= FAST_GAP_TK) begin
                        wake = 1'b1;
                    end
                end
                if (wake) begin
                    n.st = tksc_pkg::tksc_burst;
                    n.bcnt = '0;
                    n.last_gap = s.gap;
                    n.gap = '0;
                end
            end
            tksc_pkg::tksc_burst: begin
                if (s.tick) begin
                    if (s.bcnt == BURST_LAST) begin
                        n.st = tksc_pkg::tksc_eval;
                    end else begin
                        n.bcnt = s.bcnt + 9'h1;
                    end
                end
            end
            tksc_pkg::tksc_eval: begin
                n.eval = 1'b1;
                n.st = tksc_pkg::tksc_hold;
            end
            tksc_pkg::tksc_hold: begin
                n.st = tksc_pkg::tksc_sleep;
            end
        endcase

        // Sync only means something in slow mode
        if (!slow) begin
            n.sync_mode = 1'b0;
        end
        n.unit = sync_units ? (s.st == tksc_pkg::tksc_eval) : n.tick;
        n.burst = (n.st == tksc_pkg::tksc_burst);
        n.ss_oe = opt_if.valid && !slow;
        n.ss_out = n.ss_oe && n.burst;
        n.key_out = tgl_mode ? k_tgl : k_act;

        // APB read data
        if (paddr == `TKSC_ADDR_CTRL) begin
            rd_word[`TKSC_CTRL_RUN] = s.run;
            rd_word[`TKSC_CTRL_REREAD] = s.reread;
        end else if (paddr == `TKSC_ADDR_STAT) begin
            rd_word[`TKSC_ST_OUT +: `TKSC_KEYS] = s.key_out;
            rd_word[`TKSC_ST_ACT +: `TKSC_KEYS] = k_act;
            rd_word[`TKSC_ST_PEND +: `TKSC_KEYS] = k_pend;
            rd_word[`TKSC_ST_SLOW] = slow;
            rd_word[`TKSC_ST_TGL] = tgl_mode;
            rd_word[`TKSC_ST_SYNC] = s.sync_mode;
            rd_word[`TKSC_ST_INF] = tmo_inf;
            rd_word[`TKSC_ST_LONG] = tmo_long;
            rd_word[`TKSC_ST_STATE +: 2] = s.st;
        end else if (paddr == `TKSC_ADDR_OPT) begin
            rd_word[`TKSC_OPT_STRAPS +: 3] = opt_if.straps;
            rd_word[`TKSC_OPT_BUSY] = opt_if.busy;
            rd_word[`TKSC_OPT_VALID] = opt_if.valid;
            rd_word[`TKSC_OPT_REJ +: 8] = s.rejects;
        end else if (paddr == `TKSC_ADDR_GAP) begin
            rd_word[13:0] = s.last_gap;
        end

        // APB answer one cycle into the access phase
        if (acc && !s.pready) begin
            n.pready = 1'b1;
            n.prdata = pwrite ? 32'h0 : rd_word;
            n.pslverr = !(paddr == `TKSC_ADDR_CTRL || paddr == `TKSC_ADDR_STAT ||
                          paddr == `TKSC_ADDR_OPT || paddr == `TKSC_ADDR_GAP);
        end
        // Write takes effect at the edge that completes the transfer
        if (acc && s.pready && pwrite && paddr == `TKSC_ADDR_CTRL) begin
            n.run = pwdata[`TKSC_CTRL_RUN];
            n.reread = s.reread | pwdata[`TKSC_CTRL_REREAD];
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.run <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign sync_ss_out = s.ss_out;
    assign sync_ss_oe = s.ss_oe;
    assign direct_level_output = s.key_out;
    assign burst_run = s.burst;
endmodule: tksc_top
`default_nettype wire

//--- tb/tksc_top_sva.sv
// Port-level checker for the touch key option and sync control block
`timescale 1ns/1ps
`default_nettype none
`include "tksc_cfg.svh"
module tksc_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sync_ss_out,
    input wire logic sync_ss_oe,
    input wire logic [`TKSC_KEYS-1:0] direct_level_output,
    input wire logic [`TKSC_KEYS-1:0] key_recal,
    input wire logic burst_run
);
    logic [19:0] run_cnt;
    logic [16:0] up_cnt;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ---
    // Burst length and time since reset
    // ---
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt <= 20'h0;
            up_cnt <= 17'h0;
        end else if (ce) begin
            run_cnt <= burst_run ? run_cnt + 20'h1 : 20'h0;
            if (up_cnt != 17'h1ffff) begin
                up_cnt <= up_cnt + 17'h1;
            end
        end
    end

    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_ready_timing: assert property (ce && psel && penable && $past(psel && !penable) |=> pready)
        else $error("pready missing after first access cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_zero_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_oe_after_read: assert property (sync_ss_oe |-> up_cnt >= 17'hbb80)
        else $error("sync drive before a full option reading");
    a_ss_tracks_burst: assert property (sync_ss_oe |-> sync_ss_out == burst_run)
        else $error("spread drive not following the burst");
    a_burst_length: assert property ($fell(burst_run) |-> run_cnt >= 20'hc2d30 && run_cnt <= 20'hc3cd0)
        else $error("burst length off");
    a_recal_pulse: assert property (key_recal != 4'h0 |=> (key_recal & $past(key_recal)) == 4'h0)
        else $error("recalibration pulse too long");
    // Outputs only rise at key update right after a burst; a new burst may already start
    a_out_rise_burst: assert property (|(direct_level_output & ~$past(direct_level_output)) |->
        !$past(burst_run) &&
        ($past(burst_run, 2) || $past(burst_run, 3) || $past(burst_run, 4) || $past(burst_run, 5)))
        else $error("output rose outside key update");
endmodule: tksc_top_sva

bind tksc_top tksc_top_sva tksc_top_sva_inst (.pclk, .presetn, .ce, .psel, .penable, .prdata, .pready,
    .pslverr, .sync_ss_out, .sync_ss_oe, .direct_level_output, .key_recal, .burst_run);
`default_nettype wire

//--- tb/tksc_strap_model.sv
// Option strap resistors and external sync source
`timescale 1ns/1ps
`default_nettype none
module tksc_strap_model (
    input wire logic pclk,
    input wire logic [2:0] level,
    input wire logic glitch,
    input wire logic pulse,
    output logic speed_sync_strap,
    output logic timeout_strap_a,
    output logic timeout_strap_b,
    output logic sync_src
);
    // Glitch mimics a noise hit on the speed strap
    assign speed_sync_strap = level[0] ^ glitch;
    assign timeout_strap_a = level[1];
    assign timeout_strap_b = level[2];
    // Sync rests low unless a pulse is asked for
    always_ff @(posedge pclk) begin
        sync_src <= pulse;
    end
endmodule: tksc_strap_model
`default_nettype wire

//--- tb/tksc_top_test.sv
// Self-checking bench for the touch key option and sync control block
`timescale 1ns/1ps
`default_nettype none
module tksc_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] level = 3'h7;
    logic glitch = 1'b0;
    logic ce = 1'b1;
    logic pulse = 1'b0;
    logic [3:0] key_detect = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, speed_sync_strap, timeout_strap_a, timeout_strap_b;
    logic sync_src, sync_ss_out, sync_ss_oe, burst_run;
    logic [3:0] outs, recal;
    wire logic sync_line;
    int fail_count = 0;
    int n_tests = 0;

    assign sync_line = sync_ss_oe ? sync_ss_out : sync_src;

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    tksc_strap_model tksc_strap_model_inst (.pclk, .level, .glitch, .pulse, .speed_sync_strap,
        .timeout_strap_a, .timeout_strap_b, .sync_src);
    tksc_top tksc_top_inst (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .speed_sync_strap, .timeout_strap_a, .timeout_strap_b,
        .sync_ss_in(sync_line), .sync_ss_out, .sync_ss_oe, .key_detect, .direct_level_output(outs),
        .key_recal(recal), .burst_run);

    // ---
    // Shared tasks
    // ---
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask: check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask: apb

    task automatic wait_opt(input int b, input logic v);
        int n;
        n = 0;
        do begin
            repeat (200) @(posedge pclk);
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end while (rd[b] !== v && n < 500);
        if (n >= 500) fail_count++;
    endtask: wait_opt

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask: give_verdict

    // ---
    // Scenarios
    // ---
    task automatic t_reset;
        check("burst idle", 32'(burst_run), 32'h0);
        check("drive off", 32'(sync_ss_oe), 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl reset", rd, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check("opt not valid", 32'(rd[5]), 32'h0);
        apb(1'b1, 12'h00c, 32'hffffffff);
        check("ro write no err", 32'(err), 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check("gap read only", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask: t_reset

    task automatic t_first_read;
        wait_opt(5, 1'b1);
        check("opt valid", 32'(rd[5]), 32'h1);
        check("held straps", 32'(rd[2:0]), 32'h7);
        check("no rejects", 32'(rd[15:8]), 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check("slow toggle", 32'(rd[16:12]), 32'h3);
        check("no drive slow", 32'(sync_ss_oe), 32'h0);
        check("outs idle", 32'(outs), 32'h0);
        check("no recal", 32'(recal), 32'h0);
    endtask: t_first_read

    task automatic t_reject;
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h008, 32'h0);
        check("reader busy", 32'(rd[4]), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        check("reread clears", rd, 32'h1);
        repeat (20000) @(posedge pclk);
        glitch <= 1'b1;
        pulse <= 1'b1;
        repeat (4000) @(posedge pclk);
        glitch <= 1'b0;
        pulse <= 1'b0;
        check("no wake in read", 32'(burst_run), 32'h0);
        wait_opt(4, 1'b0);
        check("reject count", 32'(rd[15:8]), 32'h1);
        check("straps kept", 32'(rd[2:0]), 32'h7);
        check("still valid", 32'(rd[5]), 32'h1);
    endtask: t_reject

    task automatic t_sync_wake;
        int n;
        n = 0;
        // Frozen clock enable must hold off the wake
        ce <= 1'b0;
        pulse <= 1'b1;
        repeat (20) @(posedge pclk);
        check("frozen no wake", 32'(burst_run), 32'h0);
        ce <= 1'b1;
        while (burst_run !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        pulse <= 1'b0;
        check("sync wake", 32'(burst_run), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check("burst state", 32'(rd[21:20]), 32'h1);
        check("sync mode", 32'(rd[14]), 32'h1);
        check("no drive", 32'(sync_ss_oe), 32'h0);
        check("no spread slow", 32'(sync_ss_out), 32'h0);
    endtask: t_sync_wake

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_first_read();
        t_reject();
        t_sync_wake();
        give_verdict();
    end

    // Two option readings need about 101k cycles
    initial begin
        #600000;
        fail_count++;
        give_verdict();
    end
endmodule: tksc_top_test
`default_nettype wire
